//--- rct_defs.svh
/*
  register indices, field positions, reset values and prescaler taps of the countdown timer block.
  assumes a 32.768 kHz oscillator pin and a 32-bit APB bus; byte address = 4 * index.
*/
`ifndef RCT_DEFS_SVH
`define RCT_DEFS_SVH

`define RCT_IDX_FLAGS 8'h01
`define RCT_IDX_CFG 8'h0E
`define RCT_IDX_VAL 8'h0F

`define RCT_CFG_EN_BIT 7
`define RCT_CFG_SEL_LSB 0
`define RCT_CFG_RST_SEL 2'b11
`define RCT_CFG_RST_EN 1'b0
`define RCT_VAL_RST 8'h00

`define RCT_FL_MIN_EN 7
`define RCT_FL_SEC_EN 6
`define RCT_FL_TICK 5
`define RCT_FL_PULSE 4
`define RCT_FL_ALARM 3
`define RCT_FL_DONE 2
`define RCT_FL_AL_EN 1
`define RCT_FL_CD_EN 0
`define RCT_FL_RST 8'h00
`define RCT_FL_FLAG_MASK 8'h2C

`define RCT_TAP_8192 2
`define RCT_TAP_4096 3
`define RCT_TAP_128 8
`define RCT_TAP_64 9
`define RCT_TAP_1HZ 15
`define RCT_SEC_PER_MIN 6'd59

`endif

//--- rct_pkg.sv
/*
  types shared by the countdown timer block.
  assumes rct_defs.svh for numeric constants.
*/
package rct_pkg;
  typedef enum logic [1:0] {RCT_SRC_4096, RCT_SRC_64, RCT_SRC_1HZ, RCT_SRC_MIN} rct_src_t;
  typedef enum logic {RCT_PULSE_IDLE, RCT_PULSE_LOW} rct_pulse_t;
endpackage

//--- rct_tick_if.sv
/*
  one-cycle tick strobes from the prescaler to the timer logic.
  assumes both ends run on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface rct_tick_if;
  logic t8192;
  logic t4096;
  logic t128;
  logic t64;
  logic t1hz;
  logic t1min;
  modport src (output t8192, t4096, t128, t64, t1hz, t1min);
  modport dst (input t8192, t4096, t128, t64, t1hz, t1min);
endinterface
`default_nettype wire

//--- rct_prescaler.sv
/*
  oscillator prescaler: synchronises the 32.768 kHz pin and emits pclk-wide tick strobes.
  assumes pclk is far faster than the oscillator.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rct_defs.svh"
module rct_prescaler
  import rct_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_pin,
  rct_tick_if.src tick
);
  localparam int NTAP = 5;
  localparam int TAPS [NTAP] = '{`RCT_TAP_8192, `RCT_TAP_4096, `RCT_TAP_128, `RCT_TAP_64, `RCT_TAP_1HZ};
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic [14:0] div_q;
  logic [5:0] sec_q;
  logic [NTAP-1:0] taps;
  wire osc_rise = osc_s2_q & ~osc_s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      div_q <= 15'h0000;
      sec_q <= 6'h00;
    end else begin
      osc_s1_q <= osc_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      if (osc_rise)
        div_q <= div_q + 15'h0001;
      if (taps[4])
        sec_q <= (sec_q == `RCT_SEC_PER_MIN) ? 6'h00 : sec_q + 6'h01;
    end
  end

  // a tap fires when all bits below it roll over on an oscillator edge
  for (genvar i = 0; i < NTAP; i++) begin : g_tap
    assign taps[i] = osc_rise & (&div_q[TAPS[i]-1:0]);
  end

  assign tick.t8192 = taps[0];
  assign tick.t4096 = taps[1];
  assign tick.t128 = taps[2];
  assign tick.t64 = taps[3];
  assign tick.t1hz = taps[4];
  assign tick.t1min = taps[4] & (sec_q == `RCT_SEC_PER_MIN);
endmodule
`default_nettype wire

//--- rct_countdown_timer.sv
/*
  countdown timer, periodic tick flag and interrupt pin logic of a real-time clock, on an APB slave.
  assumes a 32.768 kHz oscillator pin, an alarm comparator pulse on pclk, and an external pull-up on the pin.
*/
// Local design decision: the APB register port.
// Operation
// - source select 00 4096 Hz, 01 64 Hz, 10 1 Hz, 11 1/60 Hz.
// - run-enable bit turns countdown on or off.
// - countdown is an 8-bit binary down-counter from the loaded value.
// - loaded zero stops the timer; 1 to 255 are valid.
// - at count one set done flag, reload and start next period.
// - reading the value register returns the live counter.
// - a new value takes effect at once and is stored for later reloads.
// - first period after enable may run up to one source tick shorter.
// - countdown interrupt is a pulse or follows done flag; enable gates it.
// - flags hold until written; writes AND into flags, others rewritten.
// - tick flag bit 5, alarm flag bit 3, done flag bit 2.
// - active-low pin, three sources wired-OR.
// - pulse select applies to both timer sources.
// - tick pulse lasts one 64 Hz period.
// - clearing tick flag ends its pulse at once.
// - in level mode clearing both minute and second enables releases pin.
// - countdown pulse width depends on source clock and count.
// - clearing done flag ends the countdown pulse at once.
// - in level mode clearing countdown interrupt enable releases pin.
// - minute or second enable sets tick flag; both behave as seconds.
// - alarm interrupt is level only, follows alarm flag when enabled.
// - run-enable at bit 7; reset gives select 11, enable 0.
`timescale 1ns/100ps
`default_nettype none
`include "rct_defs.svh"
module rct_countdown_timer
  import rct_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_pin,
  input wire logic alarm_match,
  output logic irq_pin_out,
  output logic irq_pin_oe
);
  if (ADDR_W < 10) begin : g_chk
    $error("rct_countdown_timer: ADDR_W must be at least 10");
  end

  rct_tick_if tick ();

  rct_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .osc_pin(osc_pin),
    .tick(tick)
  );

  // register state
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic run_en_q;
  rct_src_t sel_q;
  logic [7:0] reload_q;
  logic [7:0] cnt_q;
  logic [7:0] fl_q;
  logic [7:0] fl_d;
  rct_pulse_t cd_st_q;
  rct_pulse_t cd_st_d;
  rct_pulse_t ms_st_q;
  rct_pulse_t ms_st_d;
  logic irq_oe_q;
  logic irq_out_q;

  // bus decode
  wire [7:0] idx = paddr[9:2];
  wire hit_fl = (idx == `RCT_IDX_FLAGS);
  wire hit_cfg = (idx == `RCT_IDX_CFG);
  wire hit_val = (idx == `RCT_IDX_VAL);
  wire hit_any = hit_fl | hit_cfg | hit_val;
  wire setup_ph = psel & ~penable;
  wire wr_en = psel & penable & pwrite & pready_q;
  wire wr_fl = wr_en & hit_fl;
  wire wr_cfg = wr_en & hit_cfg;
  wire wr_val = wr_en & hit_val;
  wire [7:0] wbyte = pwdata[7:0];

  // read data is captured in the setup cycle, so the value word is a live snapshot
  wire [7:0] cfg_rd = {run_en_q, 5'b00000, sel_q};
  wire [7:0] rd_byte = hit_fl ? fl_q : hit_cfg ? cfg_rd : hit_val ? cnt_q : 8'h00;

  // source clock selection
  wire src_tick = (sel_q == RCT_SRC_4096) ? tick.t4096 :
                  (sel_q == RCT_SRC_64) ? tick.t64 :
                  (sel_q == RCT_SRC_1HZ) ? tick.t1hz : tick.t1min;

  // the enable is written from the bus, unrelated to the source phase, so the first
  // period starts at the next free-running tick and may be up to one tick short
  wire cd_step = run_en_q & src_tick & (cnt_q != 8'h00);
  wire cd_done = cd_step & (cnt_q == 8'h01);

  // periodic tick flag source
  wire min_en = fl_q[`RCT_FL_MIN_EN];
  wire sec_en = fl_q[`RCT_FL_SEC_EN];
  wire ms_event = sec_en ? tick.t1hz : (min_en & tick.t1min);

  // countdown pulse end: half a source period for a count of one, else one period; 1 Hz and 1/60 Hz end on the 64 Hz tap
  wire reload_one = (reload_q == 8'h01);
  wire cd_end_4096 = reload_one ? tick.t8192 : tick.t4096;
  wire cd_end_64 = reload_one ? tick.t128 : tick.t64;
  wire cd_end = (sel_q == RCT_SRC_4096) ? cd_end_4096 :
                (sel_q == RCT_SRC_64) ? cd_end_64 : tick.t64;

  // flag register: hardware set wins over a software clear in the same cycle
  always_comb begin
    fl_d = fl_q;
    if (wr_fl) begin
      fl_d = (wbyte & ~`RCT_FL_FLAG_MASK) | (wbyte & fl_q & `RCT_FL_FLAG_MASK);
    end
    if (ms_event)
      fl_d[`RCT_FL_TICK] = 1'b1;
    if (alarm_match)
      fl_d[`RCT_FL_ALARM] = 1'b1;
    if (cd_done)
      fl_d[`RCT_FL_DONE] = 1'b1;
  end

  // countdown pulse generator
  always_comb begin
    cd_st_d = cd_st_q;
    case (cd_st_q)
      RCT_PULSE_IDLE: begin
        if (cd_done)
          cd_st_d = RCT_PULSE_LOW;
      end
      RCT_PULSE_LOW: begin
        if (cd_done)
          cd_st_d = RCT_PULSE_LOW;
        else if (cd_end | ~fl_d[`RCT_FL_DONE])
          cd_st_d = RCT_PULSE_IDLE;
      end
      default: cd_st_d = RCT_PULSE_IDLE;
    endcase
  end

  // tick flag pulse generator, paced by the 64 Hz tap
  always_comb begin
    ms_st_d = ms_st_q;
    case (ms_st_q)
      RCT_PULSE_IDLE: begin
        if (ms_event)
          ms_st_d = RCT_PULSE_LOW;
      end
      RCT_PULSE_LOW: begin
        if (ms_event)
          ms_st_d = RCT_PULSE_LOW;
        else if (tick.t64 | ~fl_d[`RCT_FL_TICK])
          ms_st_d = RCT_PULSE_IDLE;
      end
      default: ms_st_d = RCT_PULSE_IDLE;
    endcase
  end

  // pin sources use next-state values so a clearing write releases the pin on its own edge
  wire pulse_mode = fl_d[`RCT_FL_PULSE];
  wire cd_irq_en = fl_d[`RCT_FL_CD_EN];
  wire ms_any_en = fl_d[`RCT_FL_MIN_EN] | fl_d[`RCT_FL_SEC_EN];
  wire cd_src = cd_irq_en & (pulse_mode ? (cd_st_d == RCT_PULSE_LOW) : fl_d[`RCT_FL_DONE]);
  wire ms_src = ms_any_en & (pulse_mode ? (ms_st_d == RCT_PULSE_LOW) : fl_d[`RCT_FL_TICK]);
  wire al_src = fl_d[`RCT_FL_AL_EN] & fl_d[`RCT_FL_ALARM];
  wire irq_any = cd_src | ms_src | al_src;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_ph;
      if (setup_ph) begin
        prdata_q <= {24'h00_0000, rd_byte};
        pslverr_q <= ~hit_any;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en_q <= `RCT_CFG_RST_EN;
      sel_q <= rct_src_t'(`RCT_CFG_RST_SEL);
    end else if (wr_cfg) begin
      run_en_q <= wbyte[`RCT_CFG_EN_BIT];
      sel_q <= rct_src_t'(wbyte[`RCT_CFG_SEL_LSB +: 2]);
    end
  end

  // a value write loads the running counter as well, so it acts at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= `RCT_VAL_RST;
      cnt_q <= `RCT_VAL_RST;
    end else if (wr_val) begin
      reload_q <= wbyte;
      cnt_q <= wbyte;
    end else if (cd_done) begin
      cnt_q <= reload_q;
    end else if (cd_step) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_q <= `RCT_FL_RST;
      cd_st_q <= RCT_PULSE_IDLE;
      ms_st_q <= RCT_PULSE_IDLE;
      irq_oe_q <= 1'b0;
      irq_out_q <= 1'b0;
    end else begin
      fl_q <= fl_d;
      cd_st_q <= cd_st_d;
      ms_st_q <= ms_st_d;
      irq_oe_q <= irq_any;
      irq_out_q <= 1'b0;
    end
  end

  // open drain: the pin is only ever pulled low
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_pin_out = irq_out_q;
  assign irq_pin_oe = irq_oe_q;
endmodule
`default_nettype wire

//--- rct_countdown_timer_props.sv
/* assertions on the apb and interrupt pin ports of the countdown timer.
   assumes a single pclk domain with presetn asynchronous active low. */
`timescale 1ns/100ps
`default_nettype none
module rct_countdown_timer_props #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic osc_pin,
  input wire logic alarm_match,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped = paddr == ADDR_W'(12'h004) || paddr == ADDR_W'(12'h038) || paddr == ADDR_W'(12'h03c);
  sequence s_setup;
    psel && !penable;
  endsequence
  // all enables off and all flags cleared in one write
  sequence s_wr_quiet;
    psel && penable && pready && pwrite && paddr == ADDR_W'(12'h004) && pwdata[7:0] == 8'h00;
  endsequence
  chk_ready_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
  chk_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  chk_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
  chk_err_unmapped: assert property ((s_setup and !mapped) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property ((s_setup and mapped) |=> !pslverr) else $error("mapped access refused");
  chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data above byte not zero");
  chk_cfg_unused: assert property (pready && !pwrite && paddr == ADDR_W'(12'h038) |-> prdata[6:2] == 5'h00)
    else $error("unused config bits not zero");
  chk_pin_data_low: assert property (irq_pin_out == 1'b0) else $error("pin data not low");
  chk_quiet_release: assert property (s_wr_quiet |-> ##2 !irq_pin_oe)
    else $error("pin still active after clearing all");
endmodule
bind rct_countdown_timer rct_countdown_timer_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .osc_pin(osc_pin), .alarm_match(alarm_match),
  .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
`default_nettype wire

//--- rct_osc_model.sv
/* far side: oscillator source and pulled-up interrupt wire.
   assumes oscillator runs at pclk/8, far faster than a real 32.768 kHz crystal, to shorten ticks. */
`timescale 1ns/100ps
`default_nettype none
module rct_osc_model (
  output var logic osc_pin,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe,
  output logic irq_n
);
  initial osc_pin = 1'b0;
  // free running, 8 pclk per period so a 4096 tick is 64 pclk
  always #80 osc_pin = ~osc_pin;
  assign irq_n = irq_pin_oe ? irq_pin_out : 1'b1;
endmodule
`default_nettype wire

//--- rtc_countdown_timer_irq_tb.sv
/* testbench for the countdown timer: apb register access, countdown, pulse and alarm pin.
   assumes the oscillator model runs at 8 pclk per period. */
`timescale 1ns/100ps
`default_nettype none
module rtc_countdown_timer_irq_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic alarm_match = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, osc_pin, irq_pin_out, irq_pin_oe, irq_n, er;
  int error_cnt = 0;
  int n_compared = 0;
  int w;
  always #10 pclk = ~pclk;
  rct_countdown_timer #(.ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_pin(osc_pin), .alarm_match(alarm_match), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
  rct_osc_model u_osc (.osc_pin(osc_pin), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe), .irq_n(irq_n));
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task rw(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk(32'h0000_0000, 32'h0000_0001);
      end_of_test;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // bounded wait for the pulled-up pin to reach a level
  task waitpin(input logic l);
    int k;
    k = 0;
    while (irq_n !== l && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    chk(irq_n, l);
    if (k >= 3000) end_of_test;
  endtask
  // counts cycles while the pin is held low, bounded so a stuck pin cannot hang the run
  task low_len(output int n);
    n = 0;
    while (irq_n === 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rw(0, 12'h038, 0); chk(rd, 32'h0000_0003);
    rw(0, 12'h03c, 0); chk(rd, 32'h0000_0000);
    rw(0, 12'h004, 0); chk(rd, 32'h0000_0000);
    rw(0, 12'h010, 0); chk(er, 1'b1);
    for (int s = 0; s < 4; s++) begin
      rw(1, 12'h038, s); rw(0, 12'h038, 0); chk(rd, s);
    end
    $display("done: registers");
    rw(1, 12'h004, 32'h0000_0001); rw(1, 12'h03c, 3); rw(1, 12'h038, 32'h0000_0080);
    waitpin(1'b0);
    rw(0, 12'h004, 0); chk(rd, 32'h0000_0005);
    rw(0, 12'h03c, 0); chk(rd >= 1 && rd <= 3, 1);
    rw(1, 12'h004, 32'h0000_0004); repeat (2) @(posedge pclk); chk(irq_n, 1'b1);
    rw(0, 12'h004, 0); chk(rd, 32'h0000_0004);
    rw(1, 12'h004, 32'h0000_0001); repeat (2) @(posedge pclk); chk(irq_n, 1'b1);
    // stop on the fast source, so a broken enable would still show ticks
    rw(1, 12'h038, 32'h0000_0000);
    rw(1, 12'h03c, 200); rw(0, 12'h03c, 0); chk(rd, 200);
    repeat (300) @(posedge pclk);
    rw(0, 12'h03c, 0); w = rd; rw(0, 12'h03c, 0); chk(rd, w);
    chk(w, 200);
    rw(0, 12'h004, 0); chk(rd, 32'h0000_0001);
    rw(1, 12'h038, 32'h0000_0003);
    $display("done: level countdown");
    rw(1, 12'h004, 32'h0000_0011); rw(1, 12'h03c, 2); rw(1, 12'h038, 32'h0000_0080);
    waitpin(1'b0);
    low_len(w); chk(w >= 60 && w <= 68, 1);
    rw(1, 12'h038, 32'h0000_0003); rw(1, 12'h004, 0);
    rw(1, 12'h004, 32'h0000_0011); rw(1, 12'h03c, 1); rw(1, 12'h038, 32'h0000_0080);
    waitpin(1'b0);
    low_len(w); chk(w >= 28 && w <= 36, 1);
    rw(1, 12'h038, 32'h0000_0003); rw(1, 12'h004, 0);
    $display("done: pulse countdown");
    rw(1, 12'h004, 32'h0000_0002);
    alarm_match <= 1'b1;
    @(posedge pclk);
    alarm_match <= 1'b0;
    waitpin(1'b0);
    rw(1, 12'h004, 32'h0000_002e); rw(0, 12'h004, 0); chk(rd, 32'h0000_000a);
    rw(1, 12'h004, 32'h0000_0002); repeat (2) @(posedge pclk); chk(irq_n, 1'b1);
    $display("done: alarm");
    end_of_test;
  end
endmodule
`default_nettype wire
